/* File: common/rtv_consts.svh */
/*
  offsets, field positions and reset values of the remote temperature value block.
  assumes it is included by bare name; definitions only.
*/
`ifndef RTV_CONSTS_SVH
`define RTV_CONSTS_SVH
`define RTV_CMD_R1_SIGNED_HIGH    8'h11
`define RTV_CMD_R2_SIGNED_HIGH    8'h12
`define RTV_CMD_R1_UNSIGNED_HIGH  8'h19
`define RTV_CMD_R2_UNSIGNED_HIGH  8'h1a
`define RTV_CMD_R1_SIGNED_LOW     8'h21
`define RTV_CMD_R2_SIGNED_LOW     8'h22
`define RTV_CMD_R1_UNSIGNED_LOW   8'h29
`define RTV_CMD_R2_UNSIGNED_LOW   8'h2a
`define RTV_CMD_FILTER_SETTING    8'h06
`define RTV_FILTER_RESET          8'h0f
`define RTV_FILTER_R1_LSB         0
`define RTV_FILTER_R2_LSB         2
`define RTV_LOW_FRAC_MSB          7
`define RTV_LOW_FRAC_LSB          3
`define RTV_LOW_FILT_LSB          3
`define RTV_LOW_FILT_MSB          4
`define RTV_UNMAPPED_READ         8'h00
`endif

/* File: common/rtv_pkg.sv */
/*
  types of the remote temperature value block.
  assumes nothing beyond a systemverilog compiler.
*/
package rtv_pkg;
  typedef logic [7:0]  rtv_byte_t;
  // conversion result: 8 integer bits (two's complement) and 5 fraction bits
  typedef logic [12:0] rtv_result_t;
  typedef enum logic [1:0] {
    RTV_IDLE   = 2'b01,
    RTV_LOCKED = 2'b10
  } rtv_lock_t;
endpackage

/* File: rtl/rtv_low_latch.sv */
/*
  per-channel low byte holder: catches the fraction bits when the high byte
  is read and releases them when the low byte is read.
  assumes read strobes are one-cycle pulses on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtv_consts.svh"
module rtv_low_latch
  import rtv_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      srst,
  input  wire logic [4:0] liveFrac,
  input  wire logic      highRead,
  input  wire logic      lowRead,
  output logic     [4:0] heldFrac,
  output logic           locked
);
  rtv_lock_t state;
  rtv_lock_t next_state;
  logic [4:0] frozen;
  logic [4:0] next_frozen;

  always_comb begin
    next_state  = state;
    next_frozen = frozen;
    if (highRead) begin
      next_state  = RTV_LOCKED;
      next_frozen = liveFrac;
    end else if (lowRead) begin
      next_state = RTV_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state  <= RTV_IDLE;
      frozen <= 5'h00;
    end else begin
      state  <= next_state;
      frozen <= next_frozen;
    end
  end

  assign locked   = (state == RTV_LOCKED);
  assign heldFrac = locked ? frozen : liveFrac;

  a_lock_holds: assert property (@(posedge sys_clk) disable iff (srst)
    locked && !highRead && !lowRead |=> locked && $stable(heldFrac))
    else $error("frozen low fraction changed");
endmodule
`default_nettype wire

/* File: rtl/rtv_value_regs.sv */
/*
  remote temperature value registers: signed and unsigned high and low bytes
  of two remote channels, plus the filter setting that gates fraction bits.
  assumes a command port decoded from the two-wire bus, one-cycle strobes,
  and conversion results delivered with a one-cycle valid on sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rtv_consts.svh"
module rtv_value_regs
  import rtv_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               srst,
  input  wire rtv_pkg::rtv_result_t r1Result,
  input  wire logic               r1Valid,
  input  wire rtv_pkg::rtv_result_t r2Result,
  input  wire logic               r2Valid,
  input  wire logic [7:0]         cmdAddr,
  input  wire logic               cmdRead,
  input  wire logic               cmdWrite,
  input  wire logic [7:0]         cmdWdata,
  output rtv_pkg::rtv_byte_t      cmdRdata,
  output logic                    cmdRvalid,
  output logic [1:0]              remote1FilterSel,
  output logic [1:0]              remote2FilterSel
);
  import rtv_pkg::*;

  rtv_result_t r1Reg;
  rtv_result_t r2Reg;
  rtv_result_t next_r1Reg;
  rtv_result_t next_r2Reg;
  rtv_byte_t   filterReg;
  rtv_byte_t   next_filterReg;
  rtv_byte_t   rdata;
  rtv_byte_t   next_rdata;
  logic        next_rvalid;
  logic [4:0]  r1Held;
  logic [4:0]  r2Held;
  logic        r1HighRd;
  logic        r2HighRd;
  logic        r1LowRd;
  logic        r2LowRd;
  logic        r1Lock;
  logic        r2Lock;
  logic        r1NegHeld;
  logic        r2NegHeld;
  logic        next_r1NegHeld;
  logic        next_r2NegHeld;
  logic        r1Neg;
  logic        r2Neg;

  // signed high byte is the integer part; unsigned uses the same bits, or 8'h00 when the result is negative
  function automatic rtv_byte_t highByte(input rtv_result_t res, input logic unsig);
    rtv_byte_t b;
    b = res[12:5];
    if (unsig && res[12])
      b = 8'h00;
    return b;
  endfunction

  function automatic rtv_byte_t lowByte(input logic [4:0] frac, input logic [1:0] sel,
                                        input logic unsig, input logic neg);
    rtv_byte_t b;
    b = 8'h00;
    b[7:5] = frac[4:2];
    if (sel != 2'b00)
      b[4:3] = frac[1:0];
    b[2:0] = 3'h0;
    if (unsig && neg)
      b = 8'h00;
    return b;
  endfunction

  always_comb begin
    next_r1Reg     = r1Reg;
    next_r2Reg     = r2Reg;
    next_filterReg = filterReg;
    if (r1Valid)
      next_r1Reg = r1Result;
    if (r2Valid)
      next_r2Reg = r2Result;
    if (cmdWrite && cmdAddr == `RTV_CMD_FILTER_SETTING)
      next_filterReg = {4'h0, cmdWdata[3:0]};
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r1Reg     <= 13'h0000;
      r2Reg     <= 13'h0000;
      filterReg <= `RTV_FILTER_RESET;
    end else begin
      r1Reg     <= next_r1Reg;
      r2Reg     <= next_r2Reg;
      filterReg <= next_filterReg;
    end
  end

  assign remote1FilterSel = filterReg[`RTV_FILTER_R1_LSB +: 2];
  assign remote2FilterSel = filterReg[`RTV_FILTER_R2_LSB +: 2];

  // high reads of either format lock
  assign r1HighRd = cmdRead && (cmdAddr == `RTV_CMD_R1_SIGNED_HIGH ||
                                cmdAddr == `RTV_CMD_R1_UNSIGNED_HIGH);
  assign r2HighRd = cmdRead && (cmdAddr == `RTV_CMD_R2_SIGNED_HIGH ||
                                cmdAddr == `RTV_CMD_R2_UNSIGNED_HIGH);
  assign r1LowRd  = cmdRead && (cmdAddr == `RTV_CMD_R1_SIGNED_LOW ||
                                cmdAddr == `RTV_CMD_R1_UNSIGNED_LOW);
  assign r2LowRd  = cmdRead && (cmdAddr == `RTV_CMD_R2_SIGNED_LOW ||
                                cmdAddr == `RTV_CMD_R2_UNSIGNED_LOW);

  rtv_low_latch u_r1Latch (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .liveFrac (r1Reg[4:0]),
    .highRead (r1HighRd),
    .lowRead  (r1LowRd),
    .heldFrac (r1Held),
    .locked   (r1Lock)
  );

  rtv_low_latch u_r2Latch (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .liveFrac (r2Reg[4:0]),
    .highRead (r2HighRd),
    .lowRead  (r2LowRd),
    .heldFrac (r2Held),
    .locked   (r2Lock)
  );

  always_comb begin
    next_r1NegHeld = r1NegHeld;
    next_r2NegHeld = r2NegHeld;
    if (r1HighRd)
      next_r1NegHeld = r1Reg[12];
    if (r2HighRd)
      next_r2NegHeld = r2Reg[12];
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r1NegHeld <= 1'b0;
      r2NegHeld <= 1'b0;
    end else begin
      r1NegHeld <= next_r1NegHeld;
      r2NegHeld <= next_r2NegHeld;
    end
  end

  assign r1Neg = r1Lock ? r1NegHeld : r1Reg[12];
  assign r2Neg = r2Lock ? r2NegHeld : r2Reg[12];

  always_comb begin
    next_rvalid = cmdRead;
    next_rdata  = rdata;
    if (cmdRead) begin
      unique case (cmdAddr)
        `RTV_CMD_R1_SIGNED_HIGH:   next_rdata = highByte(r1Reg, 1'b0);
        `RTV_CMD_R2_SIGNED_HIGH:   next_rdata = highByte(r2Reg, 1'b0);
        `RTV_CMD_R1_UNSIGNED_HIGH: next_rdata = highByte(r1Reg, 1'b1);
        `RTV_CMD_R2_UNSIGNED_HIGH: next_rdata = highByte(r2Reg, 1'b1);
        `RTV_CMD_R1_SIGNED_LOW:    next_rdata = lowByte(r1Held, remote1FilterSel, 1'b0, 1'b0);
        `RTV_CMD_R2_SIGNED_LOW:    next_rdata = lowByte(r2Held, remote2FilterSel, 1'b0, 1'b0);
        `RTV_CMD_R1_UNSIGNED_LOW:  next_rdata = lowByte(r1Held, remote1FilterSel, 1'b1,
                                                        r1Neg);
        `RTV_CMD_R2_UNSIGNED_LOW:  next_rdata = lowByte(r2Held, remote2FilterSel, 1'b1,
                                                        r2Neg);
        `RTV_CMD_FILTER_SETTING:   next_rdata = filterReg;
        default:                   next_rdata = `RTV_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdata     <= 8'h00;
      cmdRvalid <= 1'b0;
    end else begin
      rdata     <= next_rdata;
      cmdRvalid <= next_rvalid;
    end
  end

  assign cmdRdata = rdata;

  a_sig_high_value: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_SIGNED_HIGH |=>
    cmdRvalid && cmdRdata == $past(r1Reg[12:5]))
    else $error("signed high byte wrong");
  a_sig_high_r2: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R2_SIGNED_HIGH |=> cmdRdata == $past(r2Reg[12:5]))
    else $error("second signed high byte wrong");
  a_read_answer: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead |=> cmdRvalid)
    else $error("read not answered");
  a_data_holds: assert property (@(posedge sys_clk) disable iff (srst)
    !cmdRead |=> !cmdRvalid && $stable(cmdRdata))
    else $error("read data moved without a read");
  a_sig_low_r1: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_SIGNED_LOW && remote1FilterSel != 2'b00 |=>
    cmdRdata[7:3] == $past(r1Held))
    else $error("signed low byte wrong");
  a_frac_top_bits: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R2_SIGNED_LOW |=> cmdRdata[7:5] == $past(r2Held[4:2]))
    else $error("coarse fraction bits wrong");
  a_low_reserved: assert property (@(posedge sys_clk) disable iff (srst)
    $past(r1LowRd || r2LowRd) |-> cmdRdata[2:0] == 3'h0)
    else $error("reserved low bits not zero");
  a_filter_off_zero: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_SIGNED_LOW && remote1FilterSel == 2'b00 |=>
    cmdRdata[4:3] == 2'b00)
    else $error("filtered bits visible with filter off");
  a_filter_off_unsig: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_UNSIGNED_LOW && remote1FilterSel == 2'b00 |=>
    cmdRdata[4:3] == 2'b00)
    else $error("unsigned filtered bits visible with filter off");
  a_filter_on_bits: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R2_SIGNED_LOW && remote2FilterSel != 2'b00 |=>
    cmdRdata[7:3] == $past(r2Held))
    else $error("filtered low bits wrong");
  a_unsig_high_value: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R2_UNSIGNED_HIGH && !r2Reg[12] |=>
    cmdRdata == $past(r2Reg[12:5]))
    else $error("unsigned high byte wrong");
  a_unsig_high_r1: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_UNSIGNED_HIGH && !r1Reg[12] |=>
    cmdRdata == $past(r1Reg[12:5]))
    else $error("first unsigned high byte wrong");
  a_unsig_high_neg: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_UNSIGNED_HIGH && r1Reg[12] |=> cmdRdata == 8'h00)
    else $error("negative unsigned high byte not clamped");
  a_unsig_low_match: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_UNSIGNED_LOW && remote1FilterSel != 2'b00 && !r1Neg
    |=> cmdRdata[7:3] == $past(r1Held))
    else $error("unsigned low byte wrong");
  a_unsig_low_neg: assert property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R2_UNSIGNED_LOW && r2Neg |=> cmdRdata == 8'h00)
    else $error("negative unsigned low byte not clamped");
  a_write_no_change: assert property (@(posedge sys_clk) disable iff (srst)
    cmdWrite && !r1Valid |=> $stable(r1Reg))
    else $error("write altered value");
  a_write_r2_stable: assert property (@(posedge sys_clk) disable iff (srst)
    cmdWrite && !r2Valid |=> $stable(r2Reg))
    else $error("write altered second value");
  a_lock_on_high: assert property (@(posedge sys_clk) disable iff (srst)
    r1HighRd ##1 (!r1LowRd && !r1HighRd) |=> r1Lock)
    else $error("low byte not locked");
  a_lock_high_r2: assert property (@(posedge sys_clk) disable iff (srst)
    r2HighRd |=> r2Lock)
    else $error("second low byte not locked");
  a_unlock_on_low: assert property (@(posedge sys_clk) disable iff (srst)
    r1LowRd |=> !r1Lock)
    else $error("low byte not released");
  a_sign_frozen: assert property (@(posedge sys_clk) disable iff (srst)
    r1Lock && !r1HighRd && !r1LowRd |=> $stable(r1Neg))
    else $error("frozen sign changed");
  a_filter_write: assert property (@(posedge sys_clk) disable iff (srst)
    cmdWrite && cmdAddr == `RTV_CMD_FILTER_SETTING |=>
    remote1FilterSel == $past(cmdWdata[1:0]))
    else $error("filter field not written");
  a_filter_write_r2: assert property (@(posedge sys_clk) disable iff (srst)
    cmdWrite && cmdAddr == `RTV_CMD_FILTER_SETTING |=>
    remote2FilterSel == $past(cmdWdata[3:2]))
    else $error("second filter field not written");
  a_filter_keep: assert property (@(posedge sys_clk) disable iff (srst)
    !(cmdWrite && cmdAddr == `RTV_CMD_FILTER_SETTING) |=> $stable(filterReg))
    else $error("filter setting changed without a write");
  a_result_load: assert property (@(posedge sys_clk) disable iff (srst)
    r2Valid |=> r2Reg == $past(r2Result))
    else $error("result not loaded");
  a_result_r1: assert property (@(posedge sys_clk) disable iff (srst)
    r1Valid |=> r1Reg == $past(r1Result))
    else $error("first result not loaded");

  c_lock_then_low: cover property (@(posedge sys_clk) disable iff (srst)
    r1HighRd ##[1:4] r1LowRd);
  c_filtered_read: cover property (@(posedge sys_clk) disable iff (srst)
    r2LowRd && remote2FilterSel != 2'b00);
  c_negative_unsig: cover property (@(posedge sys_clk) disable iff (srst)
    cmdRead && cmdAddr == `RTV_CMD_R1_UNSIGNED_HIGH && r1Reg[12]);
  c_refresh_lock: cover property (@(posedge sys_clk) disable iff (srst)
    r1Lock && r1HighRd);
  c_frozen_sign: cover property (@(posedge sys_clk) disable iff (srst)
    r1LowRd && r1Lock && r1NegHeld != r1Reg[12]);
endmodule
`default_nettype wire

/* File: test/rtv_host_model.sv */
/*
  host side of the command port: one read or write at a time.
  assumes the device answers a read with cmdRvalid one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module rtv_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] cmdRdata,
  input  wire logic       cmdRvalid,
  output var logic  [7:0] cmdAddr,
  output var logic        cmdRead,
  output var logic        cmdWrite,
  output var logic  [7:0] cmdWdata
);
  initial begin
    cmdAddr = 8'h00;
    cmdRead = 1'b0;
    cmdWrite = 1'b0;
    cmdWdata = 8'h00;
  end

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int i;
    @(negedge sys_clk);
    cmdAddr = a;
    cmdRead = 1'b1;
    @(negedge sys_clk);
    cmdRead = 1'b0;
    cmdAddr = ~a;
    ok = 1'b0;
    d = 8'h00;
    for (i = 0; i < 4 && !ok; i++) begin
      if (cmdRvalid === 1'b1) begin
        d = cmdRdata;
        ok = 1'b1;
      end else begin
        @(negedge sys_clk);
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    cmdAddr = a;
    cmdWdata = d;
    cmdWrite = 1'b1;
    @(negedge sys_clk);
    cmdWrite = 1'b0;
    cmdAddr = ~a;
    cmdWdata = ~d;
  endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/*
  self-checking bench of the remote temperature value registers.
  assumes rtv_pkg is compiled first and the host model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rtv_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  rtv_result_t r1Result = '0;
  rtv_result_t r2Result = '0;
  logic        r1Valid = 1'b0;
  logic        r2Valid = 1'b0;
  logic [7:0]  cmdAddr;
  logic        cmdRead;
  logic        cmdWrite;
  logic [7:0]  cmdWdata;
  rtv_byte_t   cmdRdata;
  logic        cmdRvalid;
  logic [1:0]  remote1FilterSel;
  logic [1:0]  remote2FilterSel;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  always #5 sys_clk = ~sys_clk;

  rtv_value_regs rtv_value_regs_inst (.sys_clk(sys_clk), .srst(srst),
    .r1Result(r1Result), .r1Valid(r1Valid), .r2Result(r2Result), .r2Valid(r2Valid),
    .cmdAddr(cmdAddr), .cmdRead(cmdRead), .cmdWrite(cmdWrite), .cmdWdata(cmdWdata),
    .cmdRdata(cmdRdata), .cmdRvalid(cmdRvalid), .remote1FilterSel(remote1FilterSel),
    .remote2FilterSel(remote2FilterSel));

  rtv_host_model rtv_host_model_inst (.sys_clk(sys_clk), .cmdRdata(cmdRdata),
    .cmdRvalid(cmdRvalid), .cmdAddr(cmdAddr), .cmdRead(cmdRead),
    .cmdWrite(cmdWrite), .cmdWdata(cmdWdata));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit         ok;
    rtv_host_model_inst.rd(a, d, ok);
    if (!ok) begin
      fail_count++;
      $display("ERROR at %0t: no read answer at %h", $time, a);
    end
    check(d, exp);
  endtask

  task automatic load(input rtv_result_t a, input rtv_result_t b);
    @(negedge sys_clk);
    r1Result = a;
    r2Result = b;
    r1Valid = 1'b1;
    r2Valid = 1'b1;
    @(negedge sys_clk);
    r1Valid = 1'b0;
    r2Valid = 1'b0;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 3000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    check({6'h00, remote1FilterSel}, 8'h03);
    check({6'h00, remote2FilterSel}, 8'h03);
    rchk(8'h06, 8'h0f);
    $display("test reset done");
    load({8'h19, 5'b10111}, {8'hfe, 5'b01011});
    rchk(8'h11, 8'h19);
    rchk(8'h21, 8'hb8);
    rchk(8'h19, 8'h19);
    rchk(8'h29, 8'hb8);
    rchk(8'h12, 8'hfe);
    rchk(8'h22, 8'h58);
    rchk(8'h1a, 8'h00);
    rchk(8'h2a, 8'h00);
    $display("test formats done");
    rtv_host_model_inst.wr(8'h06, 8'hf4);
    check({6'h00, remote1FilterSel}, 8'h00);
    check({6'h00, remote2FilterSel}, 8'h01);
    rchk(8'h06, 8'h04);
    rchk(8'h21, 8'ha0);
    rchk(8'h22, 8'h58);
    $display("test filter done");
    rtv_host_model_inst.wr(8'h11, 8'h55);
    rtv_host_model_inst.wr(8'h29, 8'hff);
    rchk(8'h11, 8'h19);
    rchk(8'h29, 8'ha0);
    rchk(8'hff, 8'h00);
    $display("test read only done");
    rchk(8'h19, 8'h19);
    load({8'h19, 5'b01000}, {8'hfe, 5'b01011});
    rchk(8'h29, 8'ha0);
    rchk(8'h21, 8'h40);
    rchk(8'h11, 8'h19);
    load({8'h19, 5'b11111}, {8'hfe, 5'b01011});
    rchk(8'h11, 8'h19);
    rchk(8'h21, 8'he0);
    $display("test freeze done");
    load({8'hf6, 5'b10000}, {8'h7f, 5'b11000});
    rchk(8'h19, 8'h00);
    rchk(8'h11, 8'hf6);
    rchk(8'h1a, 8'h7f);
    rchk(8'h2a, 8'hc0);
    load({8'h05, 5'b01000}, {8'h7f, 5'b11000});
    rchk(8'h29, 8'h00);
    rchk(8'h29, 8'h40);
    rchk(8'h11, 8'h05);
    $display("test sign done");
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (2) @(negedge sys_clk);
    srst = 1'b0;
    check({4'h0, remote2FilterSel, remote1FilterSel}, 8'h0f);
    rchk(8'h21, 8'h00);
    $display("test reset again done");
    wrap_up();
  end
endmodule
`default_nettype wire
